/* test/csc_props.sv */
// Concurrent checks on the clock source status block ports
`timescale 1ns/100ps
`default_nettype none
module csc_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        pb_valid,
  input wire logic        pb_write,
  input wire logic [9:0]  pb_addr,
  input wire logic [31:0] pb_wdata,
  input wire logic        crystal_osc_enable,
  input wire logic        osc_mode_crystal,
  input wire logic        osc_output_pin_gpio,
  input wire logic        multiplier_enable,
  input wire logic [3:0]  multiplier_factor,
  input wire logic [3:0]  divider_factor,
  input wire logic [2:0]  multiplier_options,
  input wire logic        multiplier_out_halve,
  input wire logic [5:0]  vco_ratio_num,
  input wire logic [3:0]  vco_ratio_den,
  input wire logic        multiplier_locked,
  input wire logic        crystal_osc_ready,
  input wire logic [31:0] interrupt_flag_status
);
  logic        armed_ff;
  logic [9:0]  uaddr_ff;
  logic [31:0] keep_w;
  assign keep_w = interrupt_flag_status & ~pb_wdata;
  // Only a keyed unlock as the previous access opens a protected register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
      uaddr_ff <= 10'h000;
    end else if (pb_valid) begin
      armed_ff <= pb_write && pb_addr == 10'h018 && pb_wdata[31:24] == 8'hAA;
      uaddr_ff <= pb_wdata[9:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_clr;
    pb_valid && pb_write && pb_addr == 10'h010;
  endsequence
  sequence s_osc_wr;
    pb_valid && pb_write && pb_addr == 10'h01C;
  endsequence
  sequence s_pll_wr;
    pb_valid && pb_write && pb_addr == 10'h020;
  endsequence
  AST_CLR_ZERO_KEEPS: assert property (s_clr |=> (interrupt_flag_status & $past(keep_w)) == $past(keep_w))
    else $error("zero bit of a clear write dropped a flag");
  AST_CLR_ONE_CLEARS: assert property (s_clr ##0 pb_wdata[31] |=> !interrupt_flag_status[31])
    else $error("access error flag not cleared");
  AST_FLAG_HOLD: assert property (!(pb_valid && pb_write && pb_addr == 10'h010)
    |=> (interrupt_flag_status & $past(interrupt_flag_status)) == $past(interrupt_flag_status))
    else $error("flag dropped without a clear write");
  AST_OSC_REFUSED: assert property (s_osc_wr ##0 !(armed_ff && uaddr_ff == 10'h01C)
    |=> $stable(crystal_osc_enable) && interrupt_flag_status[31])
    else $error("locked oscillator write not refused");
  AST_OSC_TAKEN: assert property (s_osc_wr ##0 (armed_ff && uaddr_ff == 10'h01C)
    |=> crystal_osc_enable == $past(pb_wdata[16]) && osc_mode_crystal == $past(pb_wdata[0]))
    else $error("unlocked oscillator write not taken");
  AST_PLL_FROZEN: assert property (s_pll_wr ##0 multiplier_enable
    |=> $stable(multiplier_factor) && $stable(divider_factor) && $stable(multiplier_options))
    else $error("multiplier fields changed while enabled");
  AST_PLL_TAKEN: assert property (s_pll_wr ##0 (armed_ff && uaddr_ff == 10'h020) ##0 !multiplier_enable
    |=> multiplier_out_halve == $past(pb_wdata[4]) && multiplier_factor == $past(pb_wdata[19:16]))
    else $error("unlocked multiplier write not taken");
  AST_HALVE: assert property (multiplier_out_halve == multiplier_options[1])
    else $error("halve output differs from option bit one");
  AST_GPIO: assert property (osc_output_pin_gpio == !osc_mode_crystal)
    else $error("output pin use differs from mode");
  AST_VCO_DIV0: assert property (divider_factor == 4'h0
    |=> vco_ratio_den == 4'h1 && vco_ratio_num == {1'b0, $past(multiplier_factor), 1'b0} + 6'h02)
    else $error("ratio wrong for zero divider");
  AST_VCO_DIV: assert property (divider_factor != 4'h0
    |=> vco_ratio_den == $past(divider_factor) && vco_ratio_num == {2'b00, $past(multiplier_factor)} + 6'h01)
    else $error("ratio wrong for nonzero divider");
  AST_LOCK_FLAG: assert property ($rose(multiplier_locked) |-> ##[0:2] interrupt_flag_status[6])
    else $error("lock flag not latched");
  AST_RDY_FLAG: assert property ($rose(crystal_osc_ready) |-> ##[0:2] interrupt_flag_status[0])
    else $error("ready flag not latched");
  AST_RDY_NEEDS_EN: assert property (!crystal_osc_enable [*4] |-> !crystal_osc_ready)
    else $error("oscillator ready while disabled");
endmodule
`default_nettype wire

/* test/test_clock_source_status_and_control.sv */
// Self-checking bench for the clock source status block
`timescale 1ns/100ps
`default_nettype none
module test_clock_source_status_and_control;
  typedef struct packed {
    logic [3:0]  fll;
    logic        tune;
    logic [15:0] cnt;
    logic [31:0] st;
    logic [31:0] fl;
  } csc_row_t;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pb_valid = 1'b0;
  logic        pb_write = 1'b0;
  logic [9:0]  pb_addr = 10'h000;
  logic [31:0] pb_wdata = 32'h00000000;
  logic        slow_system_rc_clock = 1'b0;
  logic        osc_stable_in = 1'b0;
  logic        fast_rc_tune_done = 1'b0;
  logic [3:0]  fll = 4'h0;
  logic [15:0] fast_rc_count = 16'h0000;
  logic        multiplier_fault_in = 1'b0;
  logic        multiplier_reenable = 1'b0;
  logic [31:0] pb_rdata, interrupt_flag_status;
  logic [5:0]  vco_ratio_num;
  logic [3:0]  osc_startup, multiplier_factor, vco_ratio_den;
  logic [1:0]  osc_gain, multiplier_ref_select;
  logic        crystal_osc_enable, auto_gain_test, osc_mode_crystal, osc_output_pin_gpio;
  logic        multiplier_enable, multiplier_out_halve, multiplier_locked, crystal_osc_ready;
  int          failures = 0;
  int          tests_run = 0;
  int          n;
  // Target 1000, margin 10
  csc_row_t rows [8] = '{
    '{4'h8, 1'b0, 16'h0000, 32'h00000010, 32'h00000010}, '{4'h4, 1'b0, 16'h0000, 32'h00000008, 32'h00000008},
    '{4'h2, 1'b0, 16'h0000, 32'h00000004, 32'h00000004}, '{4'h1, 1'b0, 16'h0000, 32'h00000002, 32'h00000002},
    '{4'h0, 1'b1, 16'h03ED, 32'h00002000, 32'h00002000}, '{4'h0, 1'b1, 16'h03FC, 32'h00004000, 32'h00004000},
    '{4'h0, 1'b1, 16'h03E3, 32'h00002000, 32'h00002000}, '{4'h0, 1'b0, 16'h03E3, 32'h00004000, 32'h00004000}};
  csc_top u_dut (.ref_clk, .rst_n, .pb_valid, .pb_write, .pb_addr, .pb_wdata, .pb_rdata,
    .slow_system_rc_clock, .osc_stable_in, .fast_rc_tune_done, .fll_ref_stopped_in(fll[3]),
    .fll_sync_ready_in(fll[2]), .fll_fine_in(fll[1]), .fll_coarse_in(fll[0]), .multiplier_fault_in,
    .fast_rc_count, .fast_rc_target(16'h03E8), .tuning_lock_margin(16'h000A), .multiplier_reenable,
    .crystal_osc_enable, .osc_startup, .osc_gain, .auto_gain_test, .osc_mode_crystal, .osc_output_pin_gpio,
    .multiplier_enable, .multiplier_factor, .divider_factor(), .multiplier_options(),
    .multiplier_ref_select, .multiplier_out_halve, .vco_ratio_num, .vco_ratio_den, .multiplier_locked,
    .crystal_osc_ready, .interrupt_flag_status);
  always #5 ref_clk = ~ref_clk;
  // Slow clock 8 cycles a period keeps lock waits short
  always #40 slow_system_rc_clock = ~slow_system_rc_clock;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Idle cycle after each access keeps strobe edges apart
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    pb_valid = 1'b1;
    pb_write = w;
    pb_addr = a;
    pb_wdata = d;
    tick(1);
    pb_valid = 1'b0;
    tick(1);
  endtask
  task automatic rd(input string nm, input logic [9:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h00000000);
    chk(nm, e, pb_rdata);
  endtask
  task automatic pwr(input logic [9:0] a, input logic [31:0] d);
    acc(1'b1, 10'h018, {8'hAA, 14'h0000, a});
    acc(1'b1, a, d);
  endtask
  task give_verdict;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    give_verdict;
  end
  initial begin
    tick(6);
    rst_n = 1'b1;
    chk("gpio", 32'h1, {31'h0, osc_output_pin_gpio});
    rd("status", 10'h014, 32'h0);
    for (int i = 0; i < 8; i++) begin
      {fll, fast_rc_tune_done, fast_rc_count} = {rows[i].fll, rows[i].tune, rows[i].cnt};
      tick(4);
      rd("status", 10'h014, rows[i].st);
      rd("flags", 10'h00C, rows[i].fl);
      acc(1'b1, 10'h010, ~rows[i].fl);
      rd("flags kept", 10'h00C, rows[i].fl);
      acc(1'b1, 10'h010, rows[i].fl);
      rd("flags cleared", 10'h00C, 32'h0);
    end
    // Bad key, wrong target, unlock spent by a read
    acc(1'b1, 10'h018, 32'h5500001C);
    acc(1'b1, 10'h01C, 32'h0001020F);
    acc(1'b1, 10'h018, 32'hAA000020);
    acc(1'b1, 10'h01C, 32'h0001020F);
    acc(1'b1, 10'h018, 32'hAA00001C);
    rd("status", 10'h014, 32'h00004000);
    acc(1'b1, 10'h01C, 32'h0001020F);
    chk("osc refused", 32'h0, {31'h0, crystal_osc_enable});
    rd("access error", 10'h00C, 32'h80000000);
    acc(1'b1, 10'h010, 32'hFFFFFFFF);
    pwr(10'h01C, 32'h0001020F);
    chk("osc fields", 32'h25E, {crystal_osc_enable, osc_startup, auto_gain_test, osc_gain, osc_mode_crystal,
      osc_output_pin_gpio});
    rd("osc control", 10'h01C, 32'h0001020F);
    osc_stable_in = 1'b1;
    tick(10);
    chk("ready early", 32'h0, {31'h0, crystal_osc_ready});
    n = 0;
    while (crystal_osc_ready !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk("ready", 32'h1, {31'h0, crystal_osc_ready});
    rd("ready flag", 10'h00C, 32'h00000001);
    acc(1'b1, 10'h010, 32'hFFFFFFFF);
    pwr(10'h01C, 32'h0);
    tick(4);
    chk("osc stopped", 32'h2, {29'h0, crystal_osc_ready, osc_output_pin_gpio, crystal_osc_enable});
    pwr(10'h020, 32'h05030013);
    n = 0;
    while (multiplier_locked !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk("lock wait", 32'h1, {31'h0, n >= 32 && n <= 48});
    chk("vco", {6'h08, 4'h1, 1'b1, 1'b1, 4'h3}, {vco_ratio_num, vco_ratio_den, multiplier_out_halve,
      multiplier_enable, multiplier_factor});
    chk("pll ref", 32'h1, {30'h0, multiplier_ref_select});
    rd("pll locked", 10'h014, 32'h00004040);
    pwr(10'h020, 32'h0A0F0F13);
    rd("pll frozen", 10'h020, 32'h05030013);
    pwr(10'h020, 32'h0);
    tick(4);
    rd("pll lost", 10'h014, 32'h00004080);
    rd("pll flags", 10'h00C, 32'h000000C0);
    pwr(10'h020, 32'h00050301);
    tick(2);
    chk("vco div", {6'h06, 4'h3}, {vco_ratio_num, vco_ratio_den});
    chk("relock", 32'h1, {31'h0, multiplier_locked});
    acc(1'b1, 10'h010, 32'hFFFFFFFF);
    multiplier_reenable = 1'b1;
    tick(1);
    multiplier_reenable = 1'b0;
    tick(4);
    rd("restart flag", 10'h00C, 32'h00000040);
    multiplier_fault_in = 1'b1;
    tick(4);
    rd("pll fault", 10'h014, 32'h00004080);
    rd("fault flags", 10'h00C, 32'h000000C0);
    multiplier_fault_in = 1'b0;
    rd("unmapped", 10'h3FC, 32'h0);
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    rd("pll reset", 10'h020, 32'h0);
    rd("flags reset", 10'h00C, 32'h0);
    give_verdict;
  end
endmodule
bind csc_top csc_props u_props (.ref_clk, .rst_n, .pb_valid, .pb_write, .pb_addr, .pb_wdata,
  .crystal_osc_enable, .osc_mode_crystal, .osc_output_pin_gpio, .multiplier_enable, .multiplier_factor,
  .divider_factor, .multiplier_options, .multiplier_out_halve, .vco_ratio_num, .vco_ratio_den,
  .multiplier_locked, .crystal_osc_ready, .interrupt_flag_status);
`default_nettype wire

/* verilog/csc_consts.svh */
// Register offsets, field positions, unlock key and flag masks of the clock source status block
// Functional notes
// - Zero bits in clear write change nothing
// - One bits clear matching latched flags
// - Fast RC lock lost shows lost lock
// - Fast RC locked: tuned and within margin
// - Multiplier lock lost on disable or fault
// - Multiplier locked only when output accurate
// - Reference stopped shows stopped or slow reference
// - Sync ready gates DFLL register access
// - Fine locked shows high accuracy lock
// - Coarse locked shows medium accuracy lock
// - Oscillator ready only when stable
// - Unlock opens next access to target
// - Unlock word: key top byte, offset low
// - Enable bit starts or stops oscillator
// - Start-up field selects ready wait
// - Gain field selects gain, test gain bit
// - Mode bit: external clock or crystal
// - Count slow RC cycles before lock
// - VCO ratio from multiplier and divider
// - Multiplier register frozen while enabled
// - Latched flags hold until cleared
// - Option bit one halves output
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
`define CSC_OFF_IFS       10'h00C
`define CSC_OFF_IFC       10'h010
`define CSC_OFF_STATUS    10'h014
`define CSC_OFF_UNLOCK    10'h018
`define CSC_OFF_OSCCTRL   10'h01C
`define CSC_OFF_PLLCTRL   10'h020
`define CSC_UNLOCK_KEY    8'hAA
`define CSC_KEY_MSB       31
`define CSC_KEY_LSB       24
`define CSC_UADDR_MSB     9
`define CSC_BIT_AE        31
`define CSC_BIT_FRC_LOST  14
`define CSC_BIT_FRC_LOCK  13
`define CSC_BIT_PLL_LOST  7
`define CSC_BIT_PLL_LOCK  6
`define CSC_BIT_FLL_RCS   4
`define CSC_BIT_FLL_RDY   3
`define CSC_BIT_FLL_FINE  2
`define CSC_BIT_FLL_CRS   1
`define CSC_BIT_OSC_RDY   0
`define CSC_OSC_EN_BIT    16
`define CSC_OSC_SU_MSB    11
`define CSC_OSC_SU_LSB    8
`define CSC_OSC_AGC_BIT   3
`define CSC_OSC_GAIN_MSB  2
`define CSC_OSC_GAIN_LSB  1
`define CSC_OSC_MODE_BIT  0
`define CSC_PLL_CNT_MSB   29
`define CSC_PLL_CNT_LSB   24
`define CSC_PLL_MUL_MSB   19
`define CSC_PLL_MUL_LSB   16
`define CSC_PLL_DIV_MSB   11
`define CSC_PLL_DIV_LSB   8
`define CSC_PLL_OPT_MSB   5
`define CSC_PLL_OPT_LSB   3
`define CSC_PLL_OSC_MSB   2
`define CSC_PLL_OSC_LSB   1
`define CSC_PLL_EN_BIT    0
`define CSC_IFS_MASK      32'h800060DF
`define CSC_STATUS_MASK   32'h000060DF
`endif

/* verilog/csc_pkg.sv */
// Types shared by the clock source status block
package csc_pkg;
  typedef enum logic [1:0] {
    SEQ_OFF  = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_RUN  = 2'b11
  } csc_seq_t;

  typedef struct packed {
    logic [2:0]  rc_sync;
    logic [6:0]  pin_s1;
    logic [6:0]  pin_s2;
    logic        unlock_armed;
    logic [9:0]  unlock_addr;
    logic [31:0] ifs;
    logic [31:0] live_prev;
    logic [31:0] rdata;
    logic        osc_en;
    logic [3:0]  osc_startup;
    logic        osc_agc;
    logic [1:0]  osc_gain;
    logic        osc_mode;
    csc_seq_t    osc_seq;
    logic [15:0] osc_cnt;
    logic [5:0]  pll_count;
    logic [3:0]  pll_mul;
    logic [3:0]  pll_div;
    logic [2:0]  pll_opt;
    logic [1:0]  pll_ref;
    logic        pll_en;
    csc_seq_t    pll_seq;
    logic [5:0]  pll_cnt;
    logic        pll_lost;
    logic        frc_lost;
    logic [5:0]  vco_num;
    logic [3:0]  vco_den;
  } csc_state_t;
endpackage

/* verilog/csc_top.sv */
// Clock source status, unlock and oscillator/multiplier control registers
`timescale 1ns/100ps
`default_nettype none
`include "csc_consts.svh"
module csc_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        pb_valid,
  input  wire logic        pb_write,
  input  wire logic [9:0]  pb_addr,
  input  wire logic [31:0] pb_wdata,
  output logic      [31:0] pb_rdata,
  input  wire logic        slow_system_rc_clock,
  input  wire logic        osc_stable_in,
  input  wire logic        fast_rc_tune_done,
  input  wire logic        fll_ref_stopped_in,
  input  wire logic        fll_sync_ready_in,
  input  wire logic        fll_fine_in,
  input  wire logic        fll_coarse_in,
  input  wire logic        multiplier_fault_in,
  input  wire logic [15:0] fast_rc_count,
  input  wire logic [15:0] fast_rc_target,
  input  wire logic [15:0] tuning_lock_margin,
  input  wire logic        multiplier_reenable,
  output logic             crystal_osc_enable,
  output logic      [3:0]  osc_startup,
  output logic      [1:0]  osc_gain,
  output logic             auto_gain_test,
  output logic             osc_mode_crystal,
  output logic             osc_output_pin_gpio,
  output logic             multiplier_enable,
  output logic      [3:0]  multiplier_factor,
  output logic      [3:0]  divider_factor,
  output logic      [2:0]  multiplier_options,
  output logic      [1:0]  multiplier_ref_select,
  output logic             multiplier_out_halve,
  output logic      [5:0]  vco_ratio_num,
  output logic      [3:0]  vco_ratio_den,
  output logic             multiplier_locked,
  output logic             crystal_osc_ready,
  output logic      [31:0] interrupt_flag_status
);

  csc_pkg::csc_state_t st_ff;
  csc_pkg::csc_state_t nxt_st;

  // Distance between two counts, either order
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // Start-up wait in slow RC edges; encoding is power of two of the field
  function automatic logic [15:0] startup_wait(input logic [3:0] sel);
    startup_wait = 16'h0001 << sel;
  endfunction

  // Write strobe aimed at one register offset
  function automatic logic wr_to(input logic wr, input logic [9:0] a, input logic [9:0] off);
    wr_to = wr & (a == off);
  endfunction

  // Sequence has reached its running state
  function automatic logic seq_running(input csc_pkg::csc_seq_t s);
    seq_running = (s == csc_pkg::SEQ_RUN);
  endfunction

  logic        rc_edge;
  logic        wr_hit;
  logic        rd_hit;
  logic        wr_ifc;
  logic        wr_unlock;
  logic        wr_osc;
  logic        wr_pll;
  logic        wr_allowed;
  logic        access_error;
  logic        osc_good;
  logic        fll_rcs;
  logic        fll_rdy;
  logic        fll_fine;
  logic        fll_crs;
  logic        pll_fault;
  logic        frc_locked;
  logic        pll_locked;
  logic        pll_start;
  logic        osc_rdy;
  logic [31:0] live;
  logic [31:0] clr_mask;
  logic [31:0] rise;
  logic [31:0] rd_word;

  always_comb begin
    nxt_st = st_ff;
    // Two flops ahead of any logic; third flop only for the edge
    nxt_st.rc_sync = {st_ff.rc_sync[1:0], slow_system_rc_clock};
    nxt_st.pin_s1  = {multiplier_fault_in, fll_coarse_in, fll_fine_in, fll_sync_ready_in,
                      fll_ref_stopped_in, fast_rc_tune_done, osc_stable_in};
    nxt_st.pin_s2  = st_ff.pin_s1;
    rc_edge   = st_ff.rc_sync[1] & ~st_ff.rc_sync[2];
    osc_good  = st_ff.pin_s2[0];
    fll_rcs   = st_ff.pin_s2[2];
    fll_rdy   = st_ff.pin_s2[3];
    fll_fine  = st_ff.pin_s2[4];
    fll_crs   = st_ff.pin_s2[5];
    pll_fault = st_ff.pin_s2[6];

    wr_hit = pb_valid & pb_write;
    rd_hit = pb_valid & ~pb_write;
    // One strobe per writable offset
    wr_ifc    = wr_to(wr_hit, pb_addr, `CSC_OFF_IFC);
    wr_unlock = wr_to(wr_hit, pb_addr, `CSC_OFF_UNLOCK);
    wr_osc    = wr_to(wr_hit, pb_addr, `CSC_OFF_OSCCTRL);
    wr_pll    = wr_to(wr_hit, pb_addr, `CSC_OFF_PLLCTRL);
    // Protected write passes only right after a keyed unlock naming it
    wr_allowed = st_ff.unlock_armed & (st_ff.unlock_addr == pb_addr);
    access_error = 1'b0;

    // Unlock is spent by whatever access comes next
    if (pb_valid) begin
      nxt_st.unlock_armed = 1'b0;
    end
    if (wr_unlock) begin
      if (pb_wdata[`CSC_KEY_MSB:`CSC_KEY_LSB] == `CSC_UNLOCK_KEY) begin
        nxt_st.unlock_armed = 1'b1;
        nxt_st.unlock_addr  = pb_wdata[`CSC_UADDR_MSB:0];
      end
    end

    pll_start = 1'b0;
    if (wr_osc) begin
      if (wr_allowed) begin
        nxt_st.osc_en      = pb_wdata[`CSC_OSC_EN_BIT];
        nxt_st.osc_startup = pb_wdata[`CSC_OSC_SU_MSB:`CSC_OSC_SU_LSB];
        nxt_st.osc_agc     = pb_wdata[`CSC_OSC_AGC_BIT];
        nxt_st.osc_gain    = pb_wdata[`CSC_OSC_GAIN_MSB:`CSC_OSC_GAIN_LSB];
        nxt_st.osc_mode    = pb_wdata[`CSC_OSC_MODE_BIT];
      end else begin
        access_error = 1'b1;
      end
    end
    if (wr_pll) begin
      if (!wr_allowed) begin
        access_error = 1'b1;
      end else if (st_ff.pll_en) begin
        // Running loop keeps its setup; only shutting it down gets through
        nxt_st.pll_en = pb_wdata[`CSC_PLL_EN_BIT];
      end else begin
        nxt_st.pll_count = pb_wdata[`CSC_PLL_CNT_MSB:`CSC_PLL_CNT_LSB];
        nxt_st.pll_mul   = pb_wdata[`CSC_PLL_MUL_MSB:`CSC_PLL_MUL_LSB];
        nxt_st.pll_div   = pb_wdata[`CSC_PLL_DIV_MSB:`CSC_PLL_DIV_LSB];
        nxt_st.pll_opt   = pb_wdata[`CSC_PLL_OPT_MSB:`CSC_PLL_OPT_LSB];
        nxt_st.pll_ref   = pb_wdata[`CSC_PLL_OSC_MSB:`CSC_PLL_OSC_LSB];
        nxt_st.pll_en    = pb_wdata[`CSC_PLL_EN_BIT];
        pll_start        = pb_wdata[`CSC_PLL_EN_BIT];
      end
    end
    if (multiplier_reenable && st_ff.pll_en) begin
      pll_start = 1'b1;
    end

    // Ratio held as numerator over denominator; divider zero doubles
    if (st_ff.pll_div == 4'h0) begin
      nxt_st.vco_num = {st_ff.pll_mul + 4'h1 == 4'h0, st_ff.pll_mul + 4'h1, 1'b0};
      nxt_st.vco_den = 4'h1;
    end else begin
      nxt_st.vco_num = {1'b0, st_ff.pll_mul == 4'hF, st_ff.pll_mul + 4'h1};
      nxt_st.vco_den = st_ff.pll_div;
    end

    // Oscillator start-up sequence
    case (st_ff.osc_seq)
      csc_pkg::SEQ_OFF: begin
        nxt_st.osc_cnt = 16'h0000;
        if (st_ff.osc_en) begin
          nxt_st.osc_seq = csc_pkg::SEQ_WAIT;
        end
      end
      csc_pkg::SEQ_WAIT: begin
        if (!st_ff.osc_en) begin
          nxt_st.osc_seq = csc_pkg::SEQ_OFF;
        end else if (st_ff.osc_cnt >= startup_wait(st_ff.osc_startup)) begin
          nxt_st.osc_seq = csc_pkg::SEQ_RUN;
        end else if (rc_edge) begin
          nxt_st.osc_cnt = st_ff.osc_cnt + 16'h0001;
        end
      end
      csc_pkg::SEQ_RUN: begin
        if (!st_ff.osc_en) begin
          nxt_st.osc_seq = csc_pkg::SEQ_OFF;
        end
      end
      default: nxt_st.osc_seq = csc_pkg::SEQ_OFF;
    endcase

    // Multiplier lock sequence on slow RC edges
    // A zero count locks two cycles after the start, one cycle spent in the wait state
    case (st_ff.pll_seq)
      csc_pkg::SEQ_OFF: begin
        nxt_st.pll_cnt = 6'h00;
        if (pll_start) begin
          nxt_st.pll_seq  = csc_pkg::SEQ_WAIT;
          nxt_st.pll_lost = 1'b0;
        end
      end
      csc_pkg::SEQ_WAIT: begin
        if (!st_ff.pll_en) begin
          nxt_st.pll_seq = csc_pkg::SEQ_OFF;
        end else if (st_ff.pll_cnt == st_ff.pll_count) begin
          nxt_st.pll_seq = csc_pkg::SEQ_RUN;
        end else if (rc_edge) begin
          nxt_st.pll_cnt = st_ff.pll_cnt + 6'h01;
        end
      end
      csc_pkg::SEQ_RUN: begin
        if (!st_ff.pll_en || pll_fault) begin
          nxt_st.pll_seq  = csc_pkg::SEQ_OFF;
          nxt_st.pll_lost = 1'b1;
        end else if (pll_start) begin
          nxt_st.pll_seq = csc_pkg::SEQ_WAIT;
          nxt_st.pll_cnt = 6'h00;
        end
      end
      default: nxt_st.pll_seq = csc_pkg::SEQ_OFF;
    endcase

    frc_locked = st_ff.pin_s2[1] &
                 (abs_diff(fast_rc_count, fast_rc_target) <= tuning_lock_margin);
    // Fault drops lock at once, a cycle before the state follows
    pll_locked = seq_running(st_ff.pll_seq) & ~pll_fault;
    // Lost clears again once tuning relocks
    if (st_ff.live_prev[`CSC_BIT_FRC_LOCK] && !frc_locked) begin
      nxt_st.frc_lost = 1'b1;
    end else if (frc_locked) begin
      nxt_st.frc_lost = 1'b0;
    end

    live = 32'h00000000;
    live[`CSC_BIT_FRC_LOST] = st_ff.frc_lost;
    live[`CSC_BIT_FRC_LOCK] = frc_locked;
    live[`CSC_BIT_PLL_LOST] = st_ff.pll_lost;
    live[`CSC_BIT_PLL_LOCK] = pll_locked;
    live[`CSC_BIT_FLL_RCS]  = fll_rcs;
    live[`CSC_BIT_FLL_RDY]  = fll_rdy;
    live[`CSC_BIT_FLL_FINE] = fll_fine;
    live[`CSC_BIT_FLL_CRS]  = fll_crs;
    // Stable pin alone is not enough; the start-up wait must be over
    osc_rdy = seq_running(st_ff.osc_seq) & st_ff.osc_en & osc_good;
    live[`CSC_BIT_OSC_RDY]  = osc_rdy;
    nxt_st.live_prev = live;

    // New events beat a simultaneous clear
    rise = live & ~st_ff.live_prev;
    rise[`CSC_BIT_AE] = access_error;
    clr_mask = 32'h00000000;
    if (wr_ifc) begin
      clr_mask = pb_wdata & `CSC_IFS_MASK;
    end
    nxt_st.ifs = ((st_ff.ifs & ~clr_mask) | rise) & `CSC_IFS_MASK;

    // Write-only and unmapped offsets read zero
    rd_word = 32'h00000000;
    case (pb_addr)
      `CSC_OFF_IFS:     rd_word = st_ff.ifs;
      `CSC_OFF_STATUS:  rd_word = live & `CSC_STATUS_MASK;
      `CSC_OFF_OSCCTRL: rd_word = {15'h0000, st_ff.osc_en, 4'h0, st_ff.osc_startup,
                                   4'h0, st_ff.osc_agc, st_ff.osc_gain, st_ff.osc_mode};
      `CSC_OFF_PLLCTRL: rd_word = {2'h0, st_ff.pll_count, 4'h0, st_ff.pll_mul, 4'h0,
                                   st_ff.pll_div, 2'h0, st_ff.pll_opt, st_ff.pll_ref,
                                   st_ff.pll_en};
      default:          rd_word = 32'h00000000;
    endcase
    if (rd_hit) begin
      nxt_st.rdata = rd_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pb_rdata              = st_ff.rdata;
  assign crystal_osc_enable    = st_ff.osc_en;
  assign osc_startup           = st_ff.osc_startup;
  assign osc_gain              = st_ff.osc_gain;
  assign auto_gain_test        = st_ff.osc_agc;
  assign osc_mode_crystal      = st_ff.osc_mode;
  // External clock mode frees the output pin
  assign osc_output_pin_gpio   = ~st_ff.osc_mode;
  assign multiplier_enable     = st_ff.pll_en;
  assign multiplier_factor     = st_ff.pll_mul;
  assign divider_factor        = st_ff.pll_div;
  assign multiplier_options    = st_ff.pll_opt;
  assign multiplier_ref_select = st_ff.pll_ref;
  assign multiplier_out_halve  = st_ff.pll_opt[1];
  assign vco_ratio_num         = st_ff.vco_num;
  assign vco_ratio_den         = st_ff.vco_den;
  assign multiplier_locked     = st_ff.live_prev[`CSC_BIT_PLL_LOCK];
  assign crystal_osc_ready     = st_ff.live_prev[`CSC_BIT_OSC_RDY];
  assign interrupt_flag_status = st_ff.ifs;

endmodule
`default_nettype wire
